// ---- src/edge_detect.sv ----
`timescale 1ns/1ps
module edge_detect (
   input  wire logic                      clk,     // gear clock
   input  wire logic                      rst_n,   // synchronous reset, active low
   input  wire logic                      i_clr,   // channel gated off
   input  wire logic                      i_smp,   // sampling enable pulse
   input  wire logic                      i_level, // filtered level
   input  wire ext_int_pkg::edge_sel_type i_sel,   // trigger condition
   output logic                           o_req    // one-cycle request
);
   import ext_int_pkg::*;

   logic prev_q;
   logic hit;
   wire  rise = i_level & ~prev_q;
   wire  fall = ~i_level & prev_q;

   always_comb begin
      case (i_sel)
         EDGE_RISE: hit = rise;
         EDGE_FALL: hit = fall;
         EDGE_BOTH: hit = rise | fall;
         default:   hit = 1'b0;
      endcase
   end

   assign o_req = i_smp & ~i_clr & hit;

   always_ff @(posedge clk) begin
      if (!rst_n || i_clr) begin
         prev_q <= 1'b0;
      end else if (i_smp) begin
         prev_q <= i_level;
      end
   end
endmodule

// ---- src/ext_int_params.svh ----
// What this block does
// - each pin passes the noise canceller; only its output feeds detection
// - enable register at 0F77 holds six channel enables, reset to zero
// - clearing an enable stops that channel and wipes its control register
// - enable register bits 7 and 6 always read as zero
// - channel 1 edge select: rise, fall, both edges, 11 reserved
// - fast modes: channel 1 samples at gear clock divided by 1, 4, 8, 16
// - slow modes: channel 1 samples at low-freq clock over four
// - read-only bit 4 holds the filtered level captured at the request
// - control register at 0FD8 reads zero in bits 7 to 5, resets zero
// - a raised latch holds until accepted, cleared by software, or reset
`ifndef EXT_INT_PARAMS_SVH
`define EXT_INT_PARAMS_SVH

`define EI_EN_ADDR      16'h0F77
`define EI_CTL1_ADDR    16'h0FD8
`define EI_STAT_ADDR    16'h0FE0
`define EI_MASK_ADDR    16'h0FE1

`define EI_CTL_LVL_BIT  4
`define EI_CTL_ES_LSB   2
`define EI_CTL_NC_LSB   0

`define EI_EN_RST       8'h00
`define EI_CTL_RST      8'h00
`define EI_STAT_RST     8'h00
`define EI_MASK_RST     8'h00

`define EI_NUM_CHAN     6
`define EI_FILT_SAMPLES 3
`define EI_LF_DIV_LAST  2'h3

`endif

// ---- src/ext_int_pkg.sv ----
package ext_int_pkg;

   typedef enum logic [1:0] {
      EDGE_RISE = 2'h0,
      EDGE_FALL = 2'h1,
      EDGE_BOTH = 2'h2,
      EDGE_RSVD = 2'h3
   } edge_sel_type;

   typedef enum logic [1:0] {
      SMP_DIV1  = 2'h0,
      SMP_DIV4  = 2'h1,
      SMP_DIV8  = 2'h2,
      SMP_DIV16 = 2'h3
   } smp_div_type;

endpackage

// ---- src/ext_int_top.sv ----
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "ext_int_params.svh"
module ext_int_top #(
   parameter int NCH          = `EI_NUM_CHAN,
   parameter int FILT_SAMPLES = `EI_FILT_SAMPLES
) (
   input  wire logic           I_REF_CLK,      // gear clock, 100 MHz
   input  wire logic           I_RST_N,        // synchronous reset, active low
   input  wire logic [15:0]    I_ADDR,         // register address
   input  wire logic [7:0]     I_WDATA,        // register write data
   input  wire logic           I_WR,           // write strobe
   input  wire logic           I_RD,           // read strobe
   output logic      [7:0]     O_RDATA,        // read data, cycle after strobe
   input  wire logic           I_SLOW_MODE,    // high in slow run or slow sleep
   input  wire logic           I_LF_TICK,      // one pulse per low-freq clock
   input  wire logic [NCH-1:0] I_EXT_PIN,      // external interrupt pins
   input  wire logic [NCH-1:0] I_LATCH_ACCEPT, // cpu accepted the request
   output logic      [NCH-1:0] O_INT_LATCH,    // pending interrupt latches
   output logic                O_IRQ           // any unmasked latch set
);
   import ext_int_pkg::*;

   if (NCH < 2 || NCH > 6) begin : g_bad_nch
      $error("ext_int_top serves two to six channels");
   end

   // register state
   logic [NCH-1:0] chan_en_q;
   logic [NCH-1:0] chan_en_d;
   edge_sel_type   es1_q;
   edge_sel_type   es1_d;
   smp_div_type    nc1_q;
   smp_div_type    nc1_d;
   logic           lvl1_q;
   logic           lvl1_d;
   logic [NCH-1:0] stat_q;
   logic [NCH-1:0] stat_d;
   logic [NCH-1:0] mask_q;
   logic [NCH-1:0] mask_d;
   logic [7:0]     rdata_d;
   logic [3:0]     gdiv_q;
   logic [1:0]     lfdiv_q;

   // per channel datapath
   logic [NCH-1:0] smp;
   logic [NCH-1:0] filt;
   logic [NCH-1:0] req;
   logic           smp_ch1_fast;

   // address decode
   wire hit_en   = (I_ADDR == `EI_EN_ADDR);
   wire hit_ctl  = (I_ADDR == `EI_CTL1_ADDR);
   wire hit_stat = (I_ADDR == `EI_STAT_ADDR);
   wire hit_mask = (I_ADDR == `EI_MASK_ADDR);
   wire wr_en    = I_WR & hit_en;
   wire wr_ctl   = I_WR & hit_ctl;
   wire wr_stat  = I_WR & hit_stat;
   wire wr_mask  = I_WR & hit_mask;

   // sampling rates: gear clock taps and the low-freq divider
   wire tick_g4   = (gdiv_q[1:0] == 2'h3);
   wire tick_g8   = (gdiv_q[2:0] == 3'h7);
   wire tick_g16  = (gdiv_q == 4'hF);
   wire lf_tick4  = I_LF_TICK & (lfdiv_q == `EI_LF_DIV_LAST);

   always_comb begin
      case (nc1_q)
         SMP_DIV1:  smp_ch1_fast = 1'b1;
         SMP_DIV4:  smp_ch1_fast = tick_g4;
         SMP_DIV8:  smp_ch1_fast = tick_g8;
         SMP_DIV16: smp_ch1_fast = tick_g16;
         default:   smp_ch1_fast = 1'b1;
      endcase
   end

   // slow modes override the interval field, fast modes use the gear clock
   wire smp_ch1 = I_SLOW_MODE ? lf_tick4 : smp_ch1_fast;
   wire smp_def = I_SLOW_MODE ? lf_tick4 : 1'b1;

   // channels other than 1 have fixed rising-edge settings here and sample every gear clock in fast modes
   for (genvar k = 0; k < NCH; k++) begin : g_chan
      wire           gated = ~chan_en_q[k];
      edge_sel_type  sel;
      assign sel    = (k == 1) ? es1_q : EDGE_RISE;
      assign smp[k] = chan_en_q[k] & ((k == 1) ? smp_ch1 : smp_def);

      noise_filter #(
         .SAMPLES (FILT_SAMPLES)
      ) u_filter (
         .clk     (I_REF_CLK),
         .rst_n   (I_RST_N),
         .i_clr   (gated),
         .i_smp   (smp[k]),
         .i_pin   (I_EXT_PIN[k]),
         .o_level (filt[k])
      );

      // only the canceller output reaches the detector
      edge_detect u_edge (
         .clk     (I_REF_CLK),
         .rst_n   (I_RST_N),
         .i_clr   (gated),
         .i_smp   (smp[k]),
         .i_level (filt[k]),
         .i_sel   (sel),
         .o_req   (req[k])
      );
   end

   // register next values
   assign chan_en_d = wr_en ? I_WDATA[NCH-1:0] : chan_en_q;

   // a gated channel drops its settings and ignores writes until re-enabled
   assign es1_d  = ~chan_en_q[1] ? EDGE_RISE :
                   wr_ctl ? edge_sel_type'(I_WDATA[`EI_CTL_ES_LSB +: 2]) : es1_q;
   assign nc1_d  = ~chan_en_q[1] ? SMP_DIV1 :
                   wr_ctl ? smp_div_type'(I_WDATA[`EI_CTL_NC_LSB +: 2]) : nc1_q;
   assign lvl1_d = ~chan_en_q[1] ? 1'b0 : req[1] ? filt[1] : lvl1_q;

   // set wins over a clear in the same cycle so no request is lost
   wire [NCH-1:0] stat_clr = (wr_stat ? I_WDATA[NCH-1:0] : '0) | I_LATCH_ACCEPT;
   assign stat_d = (stat_q & ~stat_clr) | req;
   assign mask_d = wr_mask ? I_WDATA[NCH-1:0] : mask_q;

   wire [7:0] rd_en   = 8'(chan_en_q);
   wire [7:0] rd_ctl  = {3'h0, lvl1_q, es1_q, nc1_q};
   wire [7:0] rd_stat = 8'(stat_q);
   wire [7:0] rd_mask = 8'(mask_q);
   wire [7:0] rd_mux  = hit_en   ? rd_en   :
                        hit_ctl  ? rd_ctl  :
                        hit_stat ? rd_stat :
                        hit_mask ? rd_mask : 8'h00;
   // data stands only in the cycle after the strobe
   assign rdata_d = I_RD ? rd_mux : 8'h00;

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         chan_en_q <= NCH'(`EI_EN_RST);
         es1_q     <= EDGE_RISE;
         nc1_q     <= SMP_DIV1;
         lvl1_q    <= 1'b0;
         mask_q    <= NCH'(`EI_MASK_RST);
      end else begin
         chan_en_q <= chan_en_d;
         es1_q     <= es1_d;
         nc1_q     <= nc1_d;
         lvl1_q    <= lvl1_d;
         mask_q    <= mask_d;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         stat_q  <= NCH'(`EI_STAT_RST);
         O_IRQ   <= 1'b0;
         O_RDATA <= 8'h00;
      end else begin
         stat_q  <= stat_d;
         O_IRQ   <= |(stat_q & mask_q);
         O_RDATA <= rdata_d;
      end
   end

   assign O_INT_LATCH = stat_q;

   // free-running dividers keep the sampling phase independent of writes
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         gdiv_q  <= 4'h0;
         lfdiv_q <= 2'h0;
      end else begin
         gdiv_q <= gdiv_q + 4'h1;
         if (I_LF_TICK) begin
            lfdiv_q <= lfdiv_q + 2'h1;
         end
      end
   end

   // checks
   property p_en_readback;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_RD && hit_en) |=> (O_RDATA == 8'($past(chan_en_q)));
   endproperty
   a_en_readback: assert property (p_en_readback)
      else $error("enable register read back wrong");

   property p_en_top_zero;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_RD && hit_en) |=> (O_RDATA[7:6] == 2'h0);
   endproperty
   a_en_top_zero: assert property (p_en_top_zero)
      else $error("enable register upper bits not zero");

   property p_ctl_top_zero;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_RD && hit_ctl) |=> (O_RDATA[7:5] == 3'h0) && (O_RDATA[4] == $past(lvl1_q));
   endproperty
   a_ctl_top_zero: assert property (p_ctl_top_zero)
      else $error("control register read back wrong");

   property p_disable_wipes;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      $fell(chan_en_q[1]) |=> (es1_q == EDGE_RISE) && (nc1_q == SMP_DIV1) && !lvl1_q;
   endproperty
   a_disable_wipes: assert property (p_disable_wipes)
      else $error("control fields survive channel disable");

   property p_gated_quiet;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (!chan_en_q[1]) |-> (!req[1] && !smp[1]);
   endproperty
   a_gated_quiet: assert property (p_gated_quiet)
      else $error("gated channel produced activity");

   sequence s_latch_set;
      stat_q[1] && !I_LATCH_ACCEPT[1] && !(wr_stat && I_WDATA[1]);
   endsequence
   property p_latch_hold;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      s_latch_set |=> stat_q[1];
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("pending latch lost without acceptance");

   property p_set_wins;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (req[1] && I_LATCH_ACCEPT[1]) |=> stat_q[1];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("request lost against a clear");

   sequence s_div16_tick;
      !I_SLOW_MODE && (nc1_q == SMP_DIV16) && smp[1];
   endsequence
   property p_div16_gap;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      // a rewrite of the field or a mode change may cut the gap short
      s_div16_tick |=> (!smp[1] || I_SLOW_MODE || nc1_q != SMP_DIV16) [*8];
   endproperty
   a_div16_gap: assert property (p_div16_gap)
      else $error("sampling faster than gear over sixteen");

   property p_slow_rate;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_SLOW_MODE && smp[1]) |-> (I_LF_TICK && lfdiv_q == `EI_LF_DIV_LAST);
   endproperty
   a_slow_rate: assert property (p_slow_rate)
      else $error("slow mode sample not on low-freq over four");

   property p_fall_only;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (req[1] && es1_q == EDGE_FALL) |-> !filt[1];
   endproperty
   a_fall_only: assert property (p_fall_only)
      else $error("falling select fired on high level");

   property p_rsvd_quiet;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (es1_q == EDGE_RSVD) |-> !req[1];
   endproperty
   a_rsvd_quiet: assert property (p_rsvd_quiet)
      else $error("reserved select raised a request");

   property p_level_capture;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (req[1] && chan_en_q[1]) |=> (lvl1_q == $past(filt[1]));
   endproperty
   a_level_capture: assert property (p_level_capture)
      else $error("captured level does not match filtered signal");

   property p_req_on_sample;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      req[1] |-> smp[1] ##1 !req[1];
   endproperty
   a_req_on_sample: assert property (p_req_on_sample)
      else $error("request outside a sampling slot");

   property p_filtered_only;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (chan_en_q[1] && !I_SLOW_MODE && nc1_q == SMP_DIV1 && es1_q == EDGE_RISE
       && $rose(I_EXT_PIN[1])) |-> !req[1];
   endproperty
   a_filtered_only: assert property (p_filtered_only)
      else $error("raw pin edge reached the detector");

   property p_gated_held;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (!chan_en_q[1] && !$past(chan_en_q[1])) |-> !filt[1] && !lvl1_q;
   endproperty
   a_gated_held: assert property (p_gated_held)
      else $error("gated channel filter not held in reset");

   property p_w1c;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (wr_stat && I_WDATA[1] && !req[1]) |=> !stat_q[1];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("write one did not clear the latch");

   property p_accept_clear;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_LATCH_ACCEPT[1] && !req[1]) |=> !stat_q[1];
   endproperty
   a_accept_clear: assert property (p_accept_clear)
      else $error("accepted latch still pending");

   property p_irq_follow;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (|(stat_q & mask_q)) |=> O_IRQ;
   endproperty
   a_irq_follow: assert property (p_irq_follow)
      else $error("unmasked latch did not raise the interrupt");

   property p_en_write;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      wr_en |=> (chan_en_q == $past(I_WDATA[NCH-1:0]));
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable write did not land");

   property p_ctl_write;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (wr_ctl && chan_en_q[1])
         |=> (es1_q == $past(I_WDATA[3:2])) && (nc1_q == $past(I_WDATA[1:0]));
   endproperty
   a_ctl_write: assert property (p_ctl_write)
      else $error("control write did not land");

   property p_ctl_gated;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (wr_ctl && !chan_en_q[1]) |=> (es1_q == EDGE_RISE) && (nc1_q == SMP_DIV1);
   endproperty
   a_ctl_gated: assert property (p_ctl_gated)
      else $error("control write taken while channel gated");

   sequence s_div4_tick;
      !I_SLOW_MODE && (nc1_q == SMP_DIV4) && smp[1];
   endsequence
   property p_div4_gap;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      s_div4_tick |=> (!smp[1] || I_SLOW_MODE || nc1_q != SMP_DIV4) [*3];
   endproperty
   a_div4_gap: assert property (p_div4_gap)
      else $error("sampling faster than gear over four");

   property p_rise_only;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (req[1] && es1_q == EDGE_RISE) |-> filt[1];
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("rising select fired on low level");

   property p_lvl_hold;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (!req[1] && chan_en_q[1]) |=> $stable(lvl1_q);
   endproperty
   a_lvl_hold: assert property (p_lvl_hold)
      else $error("captured level moved without a request");

endmodule

// ---- src/noise_filter.sv ----
`timescale 1ns/1ps
module noise_filter #(
   parameter int SAMPLES = 3
) (
   input  wire logic clk,      // gear clock
   input  wire logic rst_n,    // synchronous reset, active low
   input  wire logic i_clr,    // channel gated off
   input  wire logic i_smp,    // sampling enable pulse
   input  wire logic i_pin,    // raw pin level
   output logic      o_level   // filtered level
);
   import ext_int_pkg::*;

   logic [SAMPLES-1:0] hist_q;

   if (SAMPLES < 2) begin : g_bad_samples
      $error("noise_filter needs at least two samples");
   end

   // the output moves only after every held sample agrees
   always_ff @(posedge clk) begin
      if (!rst_n || i_clr) begin
         hist_q  <= '0;
         o_level <= 1'b0;
      end else if (i_smp) begin
         hist_q <= {hist_q[SAMPLES-2:0], i_pin};
         if (&hist_q) begin
            o_level <= 1'b1;
         end else if (~|hist_q) begin
            o_level <= 1'b0;
         end
      end
   end
endmodule

// ---- verif/ext_pin_cpu_model.sv ----
`timescale 1ns/1ps
module ext_pin_cpu_model (
   input  wire logic       clk,         // gear clock
   input  wire logic       rst_n,       // synchronous reset, active low
   input  wire logic       i_ch1_level, // level wanted on the channel 1 pin
   input  wire logic [5:0] i_noise,     // random levels for the other pins
   input  wire logic       i_accept_on, // cpu takes pending requests
   input  wire logic [3:0] i_delay,     // cycles before the cpu takes one
   input  wire logic [5:0] i_latch,     // pending latches of the block
   output logic      [5:0] o_pins,      // external pin levels
   output logic      [5:0] o_accept     // one-cycle accept pulses
);
   logic [3:0] wait_q;

   assign o_pins = {i_noise[5:2], i_ch1_level, i_noise[0]};

   // the cpu takes the lowest pending request after a variable delay, prompt or slow
   always_ff @(posedge clk) begin
      if (!rst_n || !i_accept_on || i_latch == 6'h00 || o_accept != 6'h00) begin
         wait_q   <= 4'h0;
         o_accept <= 6'h00;
      end else if (wait_q >= i_delay) begin
         o_accept <= i_latch & ~(i_latch - 6'h01);
         wait_q   <= 4'h0;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

// ---- verif/external_interrupt_detector_tb_top.sv ----
`timescale 1ns/1ps
`include "ext_int_params.svh"
module external_interrupt_detector_tb_top;
   localparam logic [15:0] A_EN   = `EI_EN_ADDR;
   localparam logic [15:0] A_CTL  = `EI_CTL1_ADDR;
   localparam logic [15:0] A_STAT = `EI_STAT_ADDR;
   localparam logic [15:0] A_MASK = `EI_MASK_ADDR;
   logic        clk;
   logic        rst_n;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        slow;
   logic        lf_tick = 1'b0;
   logic        lf_run;
   logic [5:0]  pins;
   logic [5:0]  accept;
   logic [5:0]  latch;
   logic        irq;
   logic        ch1_lvl;
   logic [5:0]  noise = 6'h00;
   logic [3:0]  dly = 4'h0;
   logic        acc_on;
   logic [31:0] rng = 32'd53700;
   logic        hit;
   int          miscompares;
   int          cmp_count;
   int          cycles;
   int          lvl_m;
   int          div;

   ext_int_top dut (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .I_SLOW_MODE(slow), .I_LF_TICK(lf_tick),
      .I_EXT_PIN(pins), .I_LATCH_ACCEPT(accept), .O_INT_LATCH(latch), .O_IRQ(irq));

   ext_pin_cpu_model partner (
      .clk(clk), .rst_n(rst_n), .i_ch1_level(ch1_lvl), .i_noise(noise),
      .i_accept_on(acc_on), .i_delay(dly), .i_latch(latch), .o_pins(pins),
      .o_accept(accept));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk_rd(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // looks just after the edge, then hands back on the next edge so drives stay edge-aligned
   task automatic chk_out(input logic [5:0] e, input logic [5:0] m);
      #1;
      cmp_count++;
      if (latch !== e || irq !== |(e & m)) begin
         miscompares++;
         $display("BAD latch expected %h seen %h irq expected %b seen %b", e, latch, |(e & m), irq);
      end
      @(posedge clk);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk_rd(n, e, rdata);
      @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // free-running noise, cpu delay and low-freq ticks; also the hang guard
   always @(posedge clk) begin
      rng     <= xs(rng);
      noise   <= rng[5:0];
      dly     <= rng[11:8];
      lf_tick <= lf_run && (cycles % 4 == 0);
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      {rst_n, wr, rd, slow, lf_run, ch1_lvl, acc_on} = '0;
      {addr, wdata} = '0;
      lvl_m = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(A_EN, 8'h00, "enable");
      rd_reg(A_CTL, 8'h00, "control");
      rd_reg(A_STAT, 8'h00, "status");
      rd_reg(A_MASK, 8'h00, "mask");
      wr_reg(16'h0F00, rng[7:0]);
      rd_reg(16'h0F00, 8'h00, "unmapped");
      wr_reg(A_CTL, 8'h0E);
      rd_reg(A_CTL, 8'h00, "gated control");
      wr_reg(A_EN, 8'hFF);
      rd_reg(A_EN, 8'h3F, "enable");
      wr_reg(A_EN, 8'h02);
      wr_reg(A_CTL, 8'hFF);
      rd_reg(A_CTL, 8'h0F, "control");
      wr_reg(A_STAT, 8'h3F);
      $display("registers done");
      for (int es = 0; es < 4; es++) begin
         wr_reg(A_CTL, 8'(es << 2));
         wr_reg(A_STAT, 8'h3F);
         for (int lv = 1; lv >= 0; lv--) begin
            ch1_lvl <= 1'(lv);
            settle(12);
            hit = (es == 2) || (es == 0 && lv == 1) || (es == 1 && lv == 0);
            if (hit) lvl_m = lv;
            chk_out({4'h0, hit, 1'b0}, 6'h00);
            rd_reg(A_CTL, {3'h0, 1'(lvl_m), 2'(es), 2'h0}, "control");
            wr_reg(A_STAT, 8'h3F);
         end
         ch1_lvl <= 1'b1;
         settle(2);
         ch1_lvl <= 1'b0;
         settle(12);
         chk_out(6'h00, 6'h00);
      end
      $display("edge select done");
      for (int d = 0; d < 4; d++) begin
         div = (d == 0) ? 1 : (2 << d);
         wr_reg(A_CTL, 8'(d));
         wr_reg(A_STAT, 8'h3F);
         ch1_lvl <= 1'b1;
         settle(2 * div);
         chk_out(6'h00, 6'h00);
         settle(4 * div + 8);
         chk_out(6'h02, 6'h00);
         ch1_lvl <= 1'b0;
         settle(6 * div + 8);
      end
      $display("sampling interval done");
      wr_reg(A_CTL, 8'h00);
      wr_reg(A_MASK, 8'h02);
      wr_reg(A_STAT, 8'h3F);
      ch1_lvl <= 1'b1;
      settle(12);
      chk_out(6'h02, 6'h02);
      settle(30);
      rd_reg(A_STAT, 8'h02, "status");
      acc_on <= 1'b1;
      settle(24);
      chk_out(6'h00, 6'h02);
      acc_on <= 1'b0;
      wr_reg(A_MASK, 8'h00);
      ch1_lvl <= 1'b0;
      settle(12);
      ch1_lvl <= 1'b1;
      settle(12);
      chk_out(6'h02, 6'h00);
      $display("interrupt done");
      wr_reg(A_CTL, 8'h0B);
      wr_reg(A_EN, 8'h00);
      rd_reg(A_CTL, 8'h00, "control");
      wr_reg(A_STAT, 8'h3F);
      ch1_lvl <= 1'b0;
      settle(12);
      ch1_lvl <= 1'b1;
      settle(12);
      chk_out(6'h00, 6'h00);
      ch1_lvl <= 1'b0;
      wr_reg(A_EN, 8'h02);
      rd_reg(A_CTL, 8'h00, "control");
      $display("gating done");
      lf_run <= 1'b1;
      slow   <= 1'b1;
      settle(48);
      wr_reg(A_STAT, 8'h3F);
      lf_run  <= 1'b0;
      ch1_lvl <= 1'b1;
      settle(60);
      chk_out(6'h00, 6'h00);
      lf_run <= 1'b1;
      settle(150);
      chk_out(6'h02, 6'h00);
      slow <= 1'b0;
      settle(60);
      wr_reg(A_STAT, 8'h3F);
      settle(2);
      chk_out(6'h00, 6'h00);
      $display("slow mode done");
      stop_test();
   end
endmodule
